// >>> inc/ltc_pkg.sv
/*
  Constants and types shared by the tag read/write controller.
  Assumes a 200 MHz mclk; field timing is counted in field-clock ticks.
*/
package ltc_pkg;
  localparam int CLK_MHZ          = 200;
  localparam int STARTUP_TIME_US  = 1000;
  localparam int STARTUP_CYC      = STARTUP_TIME_US * CLK_MHZ;
  localparam int CFG_MOD_BIT      = 1;
  localparam int CFG_IDLEN_BIT    = 0;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [4:0] LOCK_OPEN   = 5'h00;
  localparam logic [4:0] LOCK_USER   = 5'h01;
  localparam logic [4:0] LOCK_LOCKED = 5'h0D;
  localparam logic [4:0] CFG_ADDR    = 5'h10;
  localparam logic [4:0] LAST_LONG   = 5'h0F;
  localparam logic [4:0] LAST_BIPH   = 5'h07;
  localparam logic [4:0] LAST_FSK    = 5'h0B;
  localparam logic [5:0] BIPH_PERIOD = 6'h20;
  localparam logic [5:0] BIPH_MID    = 6'h10;
  localparam logic [5:0] FSK_PERIOD  = 6'h32;
  localparam logic [2:0] FSK_HALF0   = 3'h5;
  localparam logic [2:0] FSK_HALF1   = 3'h4;
  localparam logic [6:0] D0_MIN      = 7'h12;
  localparam logic [6:0] D0_MAX      = 7'h21;
  localparam logic [6:0] D1_MIN      = 7'h32;
  localparam logic [6:0] D1_MAX      = 7'h41;
  localparam logic [6:0] DL_TIMEOUT  = 7'h40;
  localparam logic [7:0] PROG_STEP   = 8'hA2;
  localparam logic [4:0] BITS_SHORT  = 5'h02;
  localparam logic [4:0] BITS_DA     = 5'h08;
  localparam logic [4:0] BITS_WR     = 5'h10;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [3:0] {
    ST_INIT, ST_READ, ST_DL, ST_EVAL, ST_ERASE, ST_VER0, ST_PROG, ST_VER1, ST_DEFEAT
  } ltc_state_t;
  typedef enum logic [1:0] {RM_REG, RM_BYTE, RM_UPPER} ltc_rmode_t;
endpackage

// >>> design/ltc_ctrl.sv
/*
  Tag read/write controller: downlink decoder, command interpreter,
  programming sequencer and uplink modulator, plus the downlink bit FIFO.
  Assumes the field clock and gap detector arrive as asynchronous pins and
  that the memory array answers reads one mclk after ee_addr changes.
*/
`timescale 1ns/100ps
module ltc_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else if (flush)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
endmodule

// Summary of operation
// - Config bits 3-7 form the protection field
// - Field 00000: writable, dummy zeros after reset
// - Field 00001: writable, user bytes sent
// - Field 01101: locked, regular read after reset
// - FSK: 50-clock bit, zero RF/10, one RF/8
// - Biphase: boundary toggle, zero mid toggle, 32 clocks
// - Bit 0 picks 128, else 64/96 bits
// - Regular read wraps from last byte to 0
// - Last byte 15, 7 biphase, 11 FSK
// - Each read entry starts with one zero
// - Direct access: 10,0,address; repeat one byte
// - Gap interval 25 means zero, 58 one
// - Over 64 clocks without gap ends downlink
// - Start gap accepted after config load
// - Bad count or interval aborts to read
// - Write: 10,0,8 data,5 address; 16 bits
// - Opcode 00 alone reinitialises and restarts read
// - Opcode 10 alone reads identifier regularly
// - Opcode 11 reads upper bytes if short
// - Erase, verify zero, program, verify ones
// - Locked write falls back to byte read
// - Failed verify silences load until next command
// - Shadow config refreshed in read, reloaded at init
// - Programming takes 64 plus 648 field clocks
module ltc_ctrl #(
  parameter int STARTUP = ltc_pkg::STARTUP_CYC
) (
  input  wire logic  mclk,
  input  wire logic  reset_n,
  input  wire logic  field_clk_pin,
  input  wire logic  field_gap_pin,
  input  wire logic  [7:0] ee_rdata,
  input  wire logic  [7:0] ee_cfg,
  output logic       load_mod,
  output logic [4:0] ee_addr,
  output logic [7:0] ee_wdata,
  output logic       ee_erase,
  output logic       ee_prog,
  output logic [7:0] cfg_shadow,
  output logic       dl_active,
  output logic       mod_defeat
);
  import ltc_pkg::*;
  localparam int IW = $clog2(STARTUP + 1);
  ltc_state_t state;
  ltc_state_t next_state;
  ltc_rmode_t rmode;
  ltc_rmode_t go_mode;
  logic [2:0]  fc_s;
  logic [2:0]  gp_s;
  logic [IW-1:0] init_cnt;
  logic [6:0]  ivl;
  logic [7:0]  step_cnt;
  logic [5:0]  bit_cnt;
  logic [2:0]  bit_idx;
  logic [2:0]  sub_cnt;
  logic [7:0]  sh;
  logic [15:0] cmd;
  logic [4:0]  ncnt;
  logic        lead;
  logic        cur_bit;
  logic        dummy;
  logic        next_dummy;
  logic        dl_err;
  logic        go_read;
  logic [4:0]  go_addr;
  logic        ff_ready;
  logic        ff_valid;
  logic        ff_data;

  // Pin synchronisers; only the second and third stages are looked at
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fc_s <= 3'h0;
      gp_s <= 3'h0;
    end
    else
    begin
      fc_s <= {fc_s[1:0], field_clk_pin};
      gp_s <= {gp_s[1:0], field_gap_pin};
    end
  end

  wire       field_tick = fc_s[1] && !fc_s[2];
  wire       gap_rise   = gp_s[1] && !gp_s[2];
  wire [4:0] lock       = cfg_shadow[7:3];
  wire       locked     = (lock == LOCK_LOCKED);
  wire       use_fsk    = cfg_shadow[CFG_MOD_BIT];
  wire       id_long    = cfg_shadow[CFG_IDLEN_BIT];
  wire [4:0] last_byte  = id_long ? LAST_LONG : (use_fsk ? LAST_FSK : LAST_BIPH);
  wire [5:0] per_m1     = (use_fsk ? FSK_PERIOD : BIPH_PERIOD) - 6'h01;
  wire [2:0] half_m1    = (cur_bit ? FSK_HALF1 : FSK_HALF0) - 3'h1;
  wire       in_read    = (state == ST_READ);
  wire       bit_end    = in_read && field_tick && (bit_cnt == per_m1);
  wire       byte_end   = bit_end && (lead || bit_idx == 3'h7);
  wire [7:0] byte_in    = dummy ? 8'h00 : ee_rdata;
  wire       nbit       = (lead || bit_idx == 3'h7) ? byte_in[7] : sh[3'h6 - bit_idx];
  wire       ivl_zero   = (ivl >= D0_MIN) && (ivl <= D0_MAX);
  wire       ivl_one    = (ivl >= D1_MIN) && (ivl <= D1_MAX);
  wire       dl_entry   = gap_rise && (in_read || state == ST_DEFEAT);
  wire       dl_push    = (state == ST_DL) && gap_rise;
  wire       dl_bad     = dl_push && (!(ivl_zero || ivl_one) || !ff_ready);
  wire       dl_timeout = (state == ST_DL) && field_tick && (ivl == DL_TIMEOUT);
  wire       init_done  = (state == ST_INIT) && (init_cnt == IW'(STARTUP - 1));
  wire       step_end   = field_tick && (step_cnt == PROG_STEP - 8'h01);
  wire       ver0_ok    = (ee_rdata == 8'h00);
  wire       ver1_ok    = ((ee_rdata & ee_wdata) == ee_wdata);
  wire       eval_done  = (state == ST_EVAL) && !ff_valid;
  wire       is_reset   = (ncnt == BITS_SHORT) && (cmd[1:0] == 2'b00);
  wire       is_rid     = (ncnt == BITS_SHORT) && (cmd[1:0] == 2'b10);
  wire       is_upper   = (ncnt == BITS_SHORT) && (cmd[1:0] == 2'b11);
  wire       is_da      = (ncnt == BITS_DA) && (cmd[7:5] == 3'b100);
  wire       is_wr      = (ncnt == BITS_WR) && (cmd[15:13] == 3'b100);
  wire [4:0] addr_inc   = ee_addr + 5'h01;
  wire [4:0] addr_next  = (rmode == RM_BYTE) ? ee_addr :
                          (rmode == RM_UPPER) ?
                            ((ee_addr == LAST_LONG) ? last_byte + 5'h01 : addr_inc) :
                            ((ee_addr == last_byte) ? 5'h00 : addr_inc);

  ltc_fifo #(.W(1), .D(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .flush     (dl_entry),
    .in_valid  (dl_push && (ivl_zero || ivl_one)),
    .in_data   (ivl_one),
    .in_ready  (ff_ready),
    .out_valid (ff_valid),
    .out_data  (ff_data),
    .out_ready (state == ST_EVAL)
  );

  // Command decision and programming sequence
  always_comb
  begin
    next_state = state;
    go_read    = 1'b0;
    go_mode    = RM_REG;
    go_addr    = 5'h00;
    next_dummy = dummy;
    unique case (state)
      ST_INIT:
        if (init_done)
        begin
          next_state = ST_READ;
          go_read    = 1'b1;
          next_dummy = (ee_cfg[7:3] == LOCK_OPEN);
        end
      ST_READ, ST_DEFEAT:
        if (dl_entry)
          next_state = ST_DL;
      ST_DL:
        if (dl_timeout)
          next_state = ST_EVAL;
      ST_EVAL:
        if (eval_done)
        begin
          next_state = ST_READ;
          go_read    = 1'b1;
          next_dummy = 1'b0;
          if (dl_err)
            next_dummy = (lock == LOCK_OPEN);
          else if (is_reset)
          begin
            next_state = ST_INIT;
            go_read    = 1'b0;
          end
          else if (is_upper && !id_long)
          begin
            go_mode = RM_UPPER;
            go_addr = last_byte + 5'h01;
          end
          else if (is_rid || is_upper)
            go_mode = RM_REG;
          else if (is_da || (is_wr && locked))
          begin
            go_mode = RM_BYTE;
            go_addr = cmd[4:0];
          end
          else if (is_wr)
          begin
            next_state = ST_ERASE;
            go_read    = 1'b0;
          end
          else
            next_dummy = (lock == LOCK_OPEN);
        end
      ST_ERASE:
        if (step_end)
          next_state = ST_VER0;
      ST_VER0:
        if (step_end)
          next_state = ver0_ok ? ST_PROG : ST_DEFEAT;
      ST_PROG:
        if (step_end)
          next_state = ST_VER1;
      ST_VER1:
        if (step_end)
        begin
          next_state = ver1_ok ? ST_READ : ST_DEFEAT;
          go_read    = ver1_ok;
          go_mode    = RM_BYTE;
          go_addr    = ee_addr;
        end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= ST_INIT;
      dummy      <= 1'b0;
      dl_active  <= 1'b0;
      mod_defeat <= 1'b0;
      ee_erase   <= 1'b0;
      ee_prog    <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      dummy      <= next_dummy;
      dl_active  <= (next_state == ST_DL);
      mod_defeat <= (next_state == ST_DEFEAT);
      ee_erase   <= (next_state == ST_ERASE) && (state != ST_ERASE);
      ee_prog    <= (next_state == ST_PROG) && (state != ST_PROG);
    end
  end

  // Timers: startup wait, gap interval, programming step
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      init_cnt <= '0;
      ivl      <= 7'h00;
      step_cnt <= 8'h00;
    end
    else
    begin
      init_cnt <= (state == ST_INIT) ? init_cnt + 1'b1 : '0;
      if (dl_entry || dl_push)
        ivl <= 7'h00;
      else if (field_tick && ivl != 7'h7F)
        ivl <= ivl + 7'h01;
      if (state != next_state)
        step_cnt <= 8'h00;
      else if (field_tick)
        step_cnt <= step_cnt + 8'h01;
    end
  end

  // Received bit assembly; bits stay in transmitted order
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd    <= 16'h0000;
      ncnt   <= 5'h00;
      dl_err <= 1'b0;
    end
    else if (dl_entry)
    begin
      cmd    <= 16'h0000;
      ncnt   <= 5'h00;
      dl_err <= 1'b0;
    end
    else
    begin
      if (dl_bad)
        dl_err <= 1'b1;
      if (state == ST_EVAL && ff_valid)
      begin
        cmd  <= {cmd[14:0], ff_data};
        ncnt <= ncnt + 5'h01;
      end
    end
  end

  // Address, write data and shadow configuration
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ee_addr    <= 5'h00;
      ee_wdata   <= 8'h00;
      rmode      <= RM_REG;
      cfg_shadow <= CFG_RESET;
    end
    else
    begin
      if (go_read)
      begin
        ee_addr <= go_addr;
        rmode   <= go_mode;
      end
      else if (next_state == ST_ERASE && state == ST_EVAL)
      begin
        ee_addr  <= cmd[4:0];
        ee_wdata <= cmd[12:5];
      end
      else if (byte_end)
        ee_addr <= addr_next;
      if (init_done || (in_read && field_tick))
        cfg_shadow <= ee_cfg;
    end
  end

  // Uplink serialiser and load modulator
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lead     <= 1'b1;
      bit_cnt  <= 6'h00;
      bit_idx  <= 3'h0;
      sub_cnt  <= 3'h0;
      sh       <= 8'h00;
      cur_bit  <= 1'b0;
      load_mod <= 1'b0;
    end
    else if (go_read)
    begin
      lead     <= 1'b1;
      cur_bit  <= 1'b0;
      bit_cnt  <= 6'h00;
      bit_idx  <= 3'h0;
      sub_cnt  <= 3'h0;
      load_mod <= !load_mod;
    end
    else if (!in_read)
      load_mod <= 1'b0;
    else if (field_tick)
    begin
      bit_cnt <= bit_end ? 6'h00 : bit_cnt + 6'h01;
      if (bit_end)
      begin
        load_mod <= !load_mod;
        cur_bit  <= nbit;
        sub_cnt  <= 3'h0;
        lead     <= 1'b0;
        bit_idx  <= lead ? 3'h0 : bit_idx + 3'h1;
        if (lead || bit_idx == 3'h7)
          sh <= byte_in;
      end
      else if (!use_fsk)
      begin
        if (bit_cnt == BIPH_MID - 6'h01 && !cur_bit)
          load_mod <= !load_mod;
      end
      else if (sub_cnt == half_m1)
      begin
        sub_cnt  <= 3'h0;
        load_mod <= !load_mod;
      end
      else
        sub_cnt <= sub_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_LOCK_NO_ERASE: assert property (ee_erase |-> !locked)
    else $error("erase started while memory locked");
  AST_LOCKED_WRITE_BYTE: assert property (
    eval_done && !dl_err && is_wr && locked |=> in_read && rmode == RM_BYTE && lead)
    else $error("locked write did not fall back to byte read");
  AST_DUMMY_ZERO: assert property (bit_end && dummy |=> !cur_bit)
    else $error("dummy stream sent a one");
  AST_LEAD_ZERO: assert property (go_read |=> lead && !cur_bit && bit_cnt == 6'h00)
    else $error("read entry did not start with a zero");
  // Field ticks since the last boundary, counted apart from the serialiser
  logic [5:0] bit_ticks;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      bit_ticks <= 6'h00;
    else if (go_read || bit_end)
      bit_ticks <= 6'h00;
    else if (in_read && field_tick && bit_ticks != 6'h3F)
      bit_ticks <= bit_ticks + 6'h01;
  end

  AST_BIT_PERIOD: assert property (
    bit_end |-> bit_ticks == (use_fsk ? 6'h31 : 6'h1F))
    else $error("bit period wrong");
  AST_BOUNDARY_TOGGLE: assert property (bit_end |=> load_mod != $past(load_mod))
    else $error("no load toggle at bit boundary");
  AST_TIMEOUT_EVAL: assert property (dl_timeout |=> state == ST_EVAL ##1 !dl_active)
    else $error("downlink not left after gap timeout");
  AST_BAD_INTERVAL: assert property (
    dl_push && !ivl_zero && !ivl_one |=> dl_err throughout (state == ST_DL)[*1])
    else $error("bad gap interval not flagged");
  AST_WRAP_ZERO: assert property (
    byte_end && !lead && rmode == RM_REG && ee_addr == last_byte |=> ee_addr == 5'h00)
    else $error("regular read did not wrap to byte 0");
  AST_VERIFY_FAIL: assert property (
    state == ST_VER1 && step_end && !ver1_ok |=> mod_defeat && !load_mod)
    else $error("failed verify did not silence modulation");
  AST_PROG_STEPS: assert property (
    ee_erase |-> state == ST_ERASE && $past(state) == ST_EVAL)
    else $error("erase not directly after command evaluation");

  COV_PROG_OK: cover property (state == ST_VER1 && step_end && ver1_ok);
  COV_DEFEAT: cover property (mod_defeat);
  COV_UPPER: cover property (go_read && go_mode == RM_UPPER);
  COV_DA: cover property (eval_done && is_da && !dl_err);
endmodule

// >>> verif/ltc_reader_model.sv
/*
  Reader model: free-running field clock and pulse-interval gap commands.
  Assumes one caller of send_cmd at a time; gap edges land on field clock rises.
*/
`timescale 1ns/100ps
module ltc_reader_model (
  output logic field_clk_pin,
  output logic field_gap_pin
);
  initial
  begin
    field_clk_pin = 1'b0;
    field_gap_pin = 1'b0;
    forever #15 field_clk_pin = ~field_clk_pin;
  end

  // Start gap, one gap per bit MSB first; bit number bad is sent at 40 ticks
  task automatic send_cmd(input logic [16:0] bits, input int n, input int bad);
    int iv;
    int g;
    g = 15;
    @(posedge field_clk_pin);
    field_gap_pin = 1'b1;
    repeat (15) @(posedge field_clk_pin);
    field_gap_pin = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      iv = (i == bad) ? 40 : (bits[n-1-i] ? 58 : 25);
      repeat (iv - g) @(posedge field_clk_pin);
      field_gap_pin = 1'b1;
      repeat (10) @(posedge field_clk_pin);
      field_gap_pin = 1'b0;
      g = 10;
    end
    // Quiet tail that closes reception
    repeat (64 - g) @(posedge field_clk_pin);
  endtask
endmodule

// >>> verif/lf_tag_read_write_controller_bench.sv
/*
  Bench for the tag controller: memory model, uplink decoder, command checks.
  Assumes ee_cfg has the shadow layout and a field clock of 30 ns.
*/
`timescale 1ns/100ps
module lf_tag_read_write_controller_bench;
  import ltc_pkg::*;
  logic        mclk, reset_n, stuck;
  logic        field_clk_pin, field_gap_pin, load_mod, ee_erase, ee_prog, dl_active, mod_defeat;
  logic [7:0]  ee_rdata, ee_cfg, ee_wdata, cfg_shadow, rs, d;
  logic [4:0]  ee_addr;
  logic [7:0]  mem [0:16];
  logic        exq [$];
  logic        rxq [$];
  int          fail_count = 0, cmp_count = 0, erase_n = 0, prog_n = 0, k, c4, c5, en;
  logic [15:0] cb [5] = '{16'h0085, 16'h0085, 16'h0004, 16'h0003, 16'h0002};
  int          cn [5] = '{8, 8, 3, 2, 2};
  int          cbad [5] = '{99, 4, 99, 99, 99};
  int          cf [5] = '{5, 0, 0, 8, 0};
  int          chi [5] = '{5, 7, 7, 15, 7};

  ltc_reader_model rdr_u (.field_clk_pin(field_clk_pin), .field_gap_pin(field_gap_pin));
  ltc_ctrl #(.STARTUP(20)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .field_clk_pin(field_clk_pin),
    .field_gap_pin(field_gap_pin), .ee_rdata(ee_rdata), .ee_cfg(ee_cfg),
    .load_mod(load_mod), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_erase(ee_erase),
    .ee_prog(ee_prog), .cfg_shadow(cfg_shadow), .dl_active(dl_active), .mod_defeat(mod_defeat)
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Memory array: erase clears, program sets bits unless stuck
  assign ee_cfg = mem[16];
  always @(posedge mclk)
  begin
    ee_rdata <= mem[ee_addr];
    if (ee_erase === 1'b1)
    begin
      mem[ee_addr] <= 8'h00;
      erase_n <= erase_n + 1;
    end
    if (ee_prog === 1'b1)
    begin
      prog_n <= prog_n + 1;
      if (!stuck)
        mem[ee_addr] <= mem[ee_addr] | ee_wdata;
    end
  end

  function automatic logic [7:0] cfgb(input logic [4:0] lk, input logic fsk, input logic lng);
    return {lk, 1'b0, fsk, lng};
  endfunction

  function automatic logic [7:0] rnd();
    rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
    return rs;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("Counts: %0d compared, %0d wrong", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge field_clk_pin);
  endtask

  task automatic wait_up(output int t);
    t = 0;
    while (load_mod !== 1'b1)
    begin
      ticks(1);
      t++;
      if (t > 3000)
      begin
        check("uplink start", 0, 1);
        final_report;
      end
    end
  endtask

  task automatic cmd(input logic [16:0] bits, input int n);
    rdr_u.send_cmd(bits, n, 99);
  endtask

  // Expected stream: lead zero, then bytes first..hi wrapping to lo, MSB first
  task automatic stream(input int first, input int lo, input int hi, input int n, input bit dz);
    int b;
    int bi;
    int t;
    logic a;
    logic v;
    exq.delete();
    exq.push_back(1'b0);
    b = first;
    bi = 7;
    while (exq.size() < n)
    begin
      exq.push_back(dz ? 1'b0 : mem[b][bi]);
      if (bi == 0)
        b = (b == hi) ? lo : b + 1;
      bi = (bi == 0) ? 7 : bi - 1;
    end
    wait_up(t);
    ticks(4);
    a = load_mod;
    repeat (n)
    begin
      ticks(16);
      v = load_mod;
      rxq.push_back(a === v);
      ticks(16);
      a = load_mod;
      check("bit boundary toggle", a !== v, 1);
    end
    for (int i = 0; i < n; i++)
      check("uplink bit", rxq[i], exq[i]);
    rxq.delete();
  endtask

  task automatic fsk_iv(output int n4, output int n5);
    int t;
    logic v;
    n4 = 0;
    n5 = 0;
    wait_up(t);
    ticks(60);
    v = load_mod;
    for (int i = 0; i < 9; i++)
    begin
      t = 0;
      while (load_mod === v && t < 20)
      begin
        ticks(1);
        t++;
      end
      v = load_mod;
      n4 += (i > 0 && t == 4);
      n5 += (i > 0 && t == 5);
    end
  endtask

  initial
  begin
    reset_n = 1'b0;
    stuck = 1'b0;
    rs = 8'h43;
    ee_rdata = 8'h00;
    for (int i = 0; i < 16; i++)
      mem[i] = rnd();
    mem[16] = cfgb(LOCK_USER, 1'b0, 1'b0);
    repeat (16) @(negedge mclk);
    check("outputs in reset", {load_mod, ee_erase, ee_prog, dl_active, mod_defeat, cfg_shadow}, 0);
    reset_n = 1'b1;
    stream(0, 0, 7, 73, 0);
    check("shadow", cfg_shadow, mem[16]);
    $display("Test regular read done");
    for (int i = 0; i < 5; i++)
    begin
      rdr_u.send_cmd(cb[i], cn[i], cbad[i]);
      stream(cf[i], cf[i], chi[i], 17, 0);
    end
    $display("Test commands done");
    d = rnd();
    cmd({2'b10, 1'b0, d, 5'h03}, 16);
    wait_up(k);
    check("program time", k >= 645 && k <= 655, 1);
    check("write data", ee_wdata, d);
    check("write address", ee_addr, 5'h03);
    check("programmed byte", mem[3], d);
    check("erase and program", {erase_n[7:0], prog_n[7:0]}, 16'h0101);
    stream(3, 3, 3, 17, 0);
    stuck = 1'b1;
    d = rnd();
    cmd({2'b10, 1'b0, d | 8'h01, 5'h04}, 16);
    ticks(720);
    check("defeat", mod_defeat, 1);
    repeat (8)
    begin
      ticks(10);
      check("silent load", load_mod, 0);
    end
    stuck = 1'b0;
    cmd(16'h0002, 2);
    check("defeat cleared", mod_defeat, 0);
    stream(0, 0, 7, 17, 0);
    $display("Test write done");
    // A write with a seventeenth bit overflows the receive buffer and must not execute
    d = mem[2];
    en = erase_n;
    k = prog_n;
    rdr_u.send_cmd({2'b10, 1'b0, ~d, 5'h02, 1'b0}, 17, 99);
    check("downlink held", dl_active, 1);
    stream(0, 0, 7, 17, 0);
    check("overflow no erase", erase_n, en);
    check("overflow no program", prog_n, k);
    check("overflow byte kept", mem[2], d);
    check("downlink left", dl_active, 0);
    $display("Test overflow done");
    mem[16] = cfgb(LOCK_OPEN, 1'b0, 1'b0);
    cmd(16'h0000, 2);
    stream(0, 0, 7, 17, 1);
    check("shadow reload", cfg_shadow, mem[16]);
    mem[16] = cfgb(LOCK_LOCKED, 1'b0, 1'b1);
    cmd(16'h0000, 2);
    stream(0, 0, 15, 17, 0);
    en = erase_n;
    cmd({2'b10, 1'b0, d, 5'h09}, 16);
    stream(9, 9, 9, 17, 0);
    check("no erase when locked", erase_n, en);
    $display("Test lock done");
    for (int i = 0; i < 16; i++)
      mem[i] = 8'h00;
    mem[16] = cfgb(LOCK_LOCKED, 1'b1, 1'b0);
    cmd(16'h0000, 2);
    fsk_iv(c4, c5);
    check("fsk zero tone", c5, 8);
    for (int i = 0; i < 16; i++)
      mem[i] = 8'hFF;
    cmd(16'h0000, 2);
    fsk_iv(c4, c5);
    check("fsk one tone", c4, 8);
    $display("Test fsk done");
    final_report;
  end
endmodule
